// [inc/event_status_pkg.sv]
// Shared constants and types for the event status latch
package event_status_pkg;

  // Status word geometry
  localparam int unsigned STAT_W         = 24;
  localparam int unsigned FRAME_W        = 32;
  localparam int unsigned SWITCH_N       = 24;

  // Bit positions inside event_flags
  localparam int unsigned BIT_SUPPLY_LOW = 7;
  localparam int unsigned BIT_SUPPLY_HI  = 6;
  localparam int unsigned BIT_THERM_WARN = 5;
  localparam int unsigned BIT_THERM_SHUT = 4;
  localparam int unsigned BIT_SWITCH_CHG = 3;
  localparam int unsigned BIT_PARITY_ERR = 2;
  localparam int unsigned BIT_RESET_EVT  = 0;

  // Values after reset
  localparam logic [23:0] FLAGS_RST      = 24'h000001;
  localparam logic [23:0] FLAGS_CLR      = 24'h000000;
  localparam logic        INT_N_RST      = 1'h0;

  // Analog monitor levels, high while the condition is present
  typedef struct packed {
    logic supply_low_event;
    logic supply_high_event;
    logic thermal_warning_event;
    logic thermal_shutdown_event;
  } monitor_levels_t;

  // Poll sequencer state as seen by the change detector
  typedef enum logic [0:0] {
    POLL_IDLE,
    POLL_FIRST
  } poll_state_t;

endpackage : event_status_pkg

// [rtl/event_status_latch.sv]
// Read-to-clear event status register with interrupt and frame parity check
//
// Notes on behaviour
// - Bit 7 sets when a supply undervoltage starts and again when it ends.
// - Bit 6 sets when a supply overvoltage starts and again when it ends.
// - Bit 5 sets when a thermal warning starts and again when it clears.
// - Bit 4 sets when a thermal shutdown starts and again when it clears.
// - Every event bit returns to zero on a status read and otherwise holds until the next event.
// - Bit 3 sets whenever any of the 24 switch inputs crosses its threshold.
// - Bit 3 also sets when the first polling cycle after a poll trigger completes.
// - Bit 2 sets when the latest received frame fails its parity check.
// - Frames use odd parity over all bits, and a frame with an even count of ones is discarded.
// - The parity error bit is copied into the parity flag sent in each response frame.
// - After a status read the interrupt output is released at the chip-select rise ending that read.
// - Any reset sets the reset event bit; a soft reset returns only the status, poll state, parity flag and interrupt output registers to their defaults.
`timescale 1ns/100ps
module event_status_latch
  import event_status_pkg::*;
(
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                sys_rst_i,
  input  wire logic                soft_rst_i,
  // Monitor levels and switch comparators
  input  wire monitor_levels_t     levels_i,
  input  wire logic [SWITCH_N-1:0] switch_inputs_i,
  // Polling sequencer
  input  wire logic                poll_trigger_i,
  input  wire logic                poll_done_i,
  // Serial frame side
  input  wire logic                frame_done_i,
  input  wire logic [FRAME_W-1:0]  frame_bits_i,
  input  wire logic                stat_read_i,
  input  wire logic                cs_rise_i,
  // Results
  output logic [STAT_W-1:0]        event_flags_o,
  output logic [STAT_W-1:0]        read_word_o,
  output logic                     parity_frame_flag_o,
  output logic                     frame_accept_o,
  output logic [FRAME_W-1:0]       frame_word_o,
  output logic                     int_n_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection

  monitor_levels_t     levels_q;
  logic [SWITCH_N-1:0] switch_q;
  logic [SWITCH_N-1:0] switch_chg;
  logic [STAT_W-1:0]   set_vec;
  logic [STAT_W-1:0]   flags_q;
  logic [STAT_W-1:0]   flags_d;
  logic                parity_ok;
  logic                poll_first_done;
  poll_state_t         poll_q;
  logic                pend_q;

  // Previous levels; a condition already present at reset shows as one onset
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      levels_q <= '0;
      switch_q <= '0;
    end else begin
      levels_q <= levels_i;
      switch_q <= switch_inputs_i;
    end
  end

  // Per-input crossing detectors
  for (genvar g = 0; g < SWITCH_N; g++) begin : g_sw
    assign switch_chg[g] = switch_inputs_i[g] ^ switch_q[g];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Polling: only the first completed cycle after a trigger flags

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      poll_q <= POLL_IDLE;
    end else if (soft_rst_i) begin
      poll_q <= POLL_IDLE;
    end else begin
      unique case (poll_q)
        POLL_IDLE:  if (poll_trigger_i) poll_q <= POLL_FIRST;
        POLL_FIRST: if (poll_done_i)    poll_q <= POLL_IDLE;
      endcase
    end
  end

  assign poll_first_done = (poll_q == POLL_FIRST) && poll_done_i;

  // Odd parity over the whole frame, parity bit included
  assign parity_ok = ^frame_bits_i;

  //////////////////////////////////////////////////////////////////////////////
  // Set vector; both edges of each monitor level count as events

  always_comb begin
    set_vec                 = '0;
    set_vec[BIT_SUPPLY_LOW] = levels_i.supply_low_event ^ levels_q.supply_low_event;
    set_vec[BIT_SUPPLY_HI]  = levels_i.supply_high_event ^ levels_q.supply_high_event;
    set_vec[BIT_THERM_WARN] = levels_i.thermal_warning_event ^ levels_q.thermal_warning_event;
    set_vec[BIT_THERM_SHUT] = levels_i.thermal_shutdown_event ^ levels_q.thermal_shutdown_event;
    set_vec[BIT_SWITCH_CHG] = (|switch_chg) || poll_first_done;
    set_vec[BIT_PARITY_ERR] = frame_done_i && !parity_ok;
  end

  // Read clears, but an event in the same cycle survives the clear
  always_comb begin
    flags_d = (stat_read_i ? FLAGS_CLR : flags_q) | set_vec;
  end

  // Status register; soft reset reloads the default, reset bit included
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_q <= FLAGS_RST;
    end else if (soft_rst_i) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign event_flags_o = flags_q;

  //////////////////////////////////////////////////////////////////////////////
  // Read snapshot and frame acceptance

  // Snapshot holds pre-clear contents plus same-cycle events for shifting out
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      read_word_o <= FLAGS_CLR;
    end else if (stat_read_i) begin
      read_word_o <= flags_q | set_vec;
    end
  end

  // Only frames with odd parity are passed on
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_accept_o <= 1'h0;
      frame_word_o   <= '0;
    end else begin
      frame_accept_o <= frame_done_i && parity_ok;
      if (frame_done_i && parity_ok) begin
        frame_word_o <= frame_bits_i;
      end
    end
  end

  // Mirror of the parity error bit for the response status field
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      parity_frame_flag_o <= FLAGS_RST[BIT_PARITY_ERR];
    end else if (soft_rst_i) begin
      parity_frame_flag_o <= FLAGS_RST[BIT_PARITY_ERR];
    end else begin
      parity_frame_flag_o <= flags_d[BIT_PARITY_ERR];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt; held through the read frame so the host sees a stable pin

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_q <= 1'h0;
    end else if (stat_read_i) begin
      pend_q <= 1'h1;
    end else if (cs_rise_i) begin
      pend_q <= 1'h0;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      int_n_o <= INT_N_RST;
    end else if (soft_rst_i) begin
      int_n_o <= INT_N_RST;
    end else if ((pend_q || stat_read_i) && !cs_rise_i) begin
      int_n_o <= int_n_o && ~|set_vec;
    end else begin
      int_n_o <= ~|flags_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  // Read command, two held cycles, then the chip-select rise that ends the read
  sequence s_read_then_rise;
    stat_read_i && !cs_rise_i && !soft_rst_i
    ##1 (pend_q && !cs_rise_i && !soft_rst_i)[*2]
    ##1 pend_q && cs_rise_i && !stat_read_i && !soft_rst_i;
  endsequence

  // Trigger from idle, then the first polling cycle completing on the very next cycle
  sequence s_trigger_then_done;
    poll_q == POLL_IDLE && poll_trigger_i && !soft_rst_i ##1 poll_done_i && !soft_rst_i;
  endsequence

  property p_low_edge;
    @(posedge clock_i) disable iff (sys_rst_i)
      !soft_rst_i && (levels_i.supply_low_event != levels_q.supply_low_event) |=> flags_q[BIT_SUPPLY_LOW];
  endproperty
  a_low_edge: assert property (p_low_edge) else $error("supply low edge not latched");

  property p_high_edge;
    @(posedge clock_i) disable iff (sys_rst_i)
      !soft_rst_i && (levels_i.supply_high_event != levels_q.supply_high_event)
      |=> flags_q[BIT_SUPPLY_HI] && (read_word_o == $past(read_word_o) || $past(stat_read_i));
  endproperty
  a_high_edge: assert property (p_high_edge) else $error("supply high edge not latched");

  property p_warn_edge;
    @(posedge clock_i) disable iff (sys_rst_i)
      !soft_rst_i && (levels_i.thermal_warning_event != levels_q.thermal_warning_event) |=> flags_q[BIT_THERM_WARN];
  endproperty
  a_warn_edge: assert property (p_warn_edge) else $error("thermal warning edge not latched");

  property p_shut_edge;
    @(posedge clock_i) disable iff (sys_rst_i)
      !soft_rst_i && (levels_i.thermal_shutdown_event != levels_q.thermal_shutdown_event)
      |=> flags_q[BIT_THERM_SHUT];
  endproperty
  a_shut_edge: assert property (p_shut_edge) else $error("thermal shutdown edge not latched");

  property p_read_clear;
    @(posedge clock_i) disable iff (sys_rst_i)
      stat_read_i && !soft_rst_i && set_vec == FLAGS_CLR |=> flags_q == FLAGS_CLR && read_word_o == $past(flags_q);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

  property p_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
      !stat_read_i && !soft_rst_i && set_vec == FLAGS_CLR |=> $stable(flags_q);
  endproperty
  a_hold: assert property (p_hold) else $error("status changed without cause");

  property p_switch;
    @(posedge clock_i) disable iff (sys_rst_i)
      !soft_rst_i && (switch_inputs_i != switch_q) |=> flags_q[BIT_SWITCH_CHG];
  endproperty
  a_switch: assert property (p_switch) else $error("switch crossing not latched");

  property p_poll_first;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_trigger_then_done |=> flags_q[BIT_SWITCH_CHG];
  endproperty
  a_poll_first: assert property (p_poll_first) else $error("first poll cycle not flagged");

  property p_parity;
    @(posedge clock_i) disable iff (sys_rst_i)
      frame_done_i && !soft_rst_i |=> (frame_accept_o != flags_q[BIT_PARITY_ERR] || $past(flags_q[BIT_PARITY_ERR]))
      && frame_accept_o == $past(parity_ok);
  endproperty
  a_parity: assert property (p_parity) else $error("parity verdict wrong");

  property p_good_frame;
    @(posedge clock_i) disable iff (sys_rst_i)
      frame_done_i && parity_ok |=> frame_accept_o && frame_word_o == $past(frame_bits_i);
  endproperty
  a_good_frame: assert property (p_good_frame) else $error("odd frame not passed on");

  property p_bad_frame;
    @(posedge clock_i) disable iff (sys_rst_i)
      frame_done_i && !parity_ok && !soft_rst_i |=> !frame_accept_o && parity_frame_flag_o;
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("even frame not discarded and flagged");

  property p_mirror;
    @(posedge clock_i) disable iff (sys_rst_i)
      parity_frame_flag_o == flags_q[BIT_PARITY_ERR];
  endproperty
  a_mirror: assert property (p_mirror) else $error("parity flag not mirrored");

  property p_release;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_read_then_rise ##0 !(|flags_d) |=> int_n_o;
  endproperty
  a_release: assert property (p_release) else $error("interrupt not released at chip select rise");

  property p_int_release;
    @(posedge clock_i) disable iff (sys_rst_i)
      pend_q && cs_rise_i && !stat_read_i && !soft_rst_i && !(|flags_d) |=> int_n_o;
  endproperty
  a_int_release: assert property (p_int_release) else $error("interrupt held after read frame end");

  property p_int_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
      pend_q && !cs_rise_i && !int_n_o && !soft_rst_i |=> !int_n_o;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt released before frame end");

  property p_soft_reset;
    @(posedge clock_i) disable iff (sys_rst_i)
      soft_rst_i |=> flags_q == FLAGS_RST && !int_n_o;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not restore defaults");

  property p_int_assert;
    @(posedge clock_i) disable iff (sys_rst_i)
      !pend_q && !stat_read_i && |flags_d |=> !int_n_o;
  endproperty
  a_int_assert: assert property (p_int_assert) else $error("interrupt not asserted on set flag");

endmodule : event_status_latch

// [tb/host_model.sv]
// Host controller model: frame strobes and status reads
`timescale 1ns/100ps
module host_model (
  // Clock
  input  wire logic        clock_i,
  // Strobes toward the latch
  output logic             frame_done_o,
  output logic [31:0]      frame_bits_o,
  output logic             stat_read_o,
  output logic             cs_rise_o
);
  // Idle levels; data shows a junk pattern outside frames
  initial begin
    frame_done_o = 1'h0;
    frame_bits_o = 32'hA5A5A5A5;
    stat_read_o  = 1'h0;
    cs_rise_o    = 1'h0;
  end
  ////////////////////////////////////////
  // Parity bit in bit 0; bad turns the count even on purpose
  function automatic logic [31:0] seal(input logic [31:0] w, input logic bad);
    return {w[31:1], ~^w[31:1] ^ bad};
  endfunction : seal
  // Two frames on consecutive cycles, line inverted afterwards
  task automatic frames(input logic [31:0] a, input logic [31:0] b);
    @(negedge clock_i);
    frame_done_o = 1'h1;
    frame_bits_o = a;
    @(negedge clock_i);
    frame_bits_o = b;
    @(negedge clock_i);
    frame_done_o = 1'h0;
    frame_bits_o = ~b;
  endtask : frames
  // Read command pulse
  task automatic read_cmd();
    @(negedge clock_i);
    stat_read_o = 1'h1;
    @(negedge clock_i);
    stat_read_o = 1'h0;
  endtask : read_cmd
  // Chip select rise a little after the command
  task automatic cs_end();
    repeat (2) @(negedge clock_i);
    cs_rise_o = 1'h1;
    @(negedge clock_i);
    cs_rise_o = 1'h0;
  endtask : cs_end
endmodule : host_model

// [tb/event_status_latch_tb.sv]
// Self-checking bench for the event status latch
`timescale 1ns/100ps
module event_status_latch_tb
  import event_status_pkg::*;
;
  logic                clock_i = 1'h0;
  logic                sys_rst_i = 1'h1;
  logic                soft_rst_i = 1'h0;
  logic                poll_trigger_i = 1'h0;
  logic                poll_done_i = 1'h0;
  monitor_levels_t     levels_i = '0;
  logic [SWITCH_N-1:0] sw = '0;
  logic                frame_done, stat_read, cs_rise, pflag, accept, int_n;
  logic                rd_d = 1'h0;
  logic [FRAME_W-1:0]  frame_bits, frame_word;
  logic [STAT_W-1:0]   flags, read_word;
  logic [31:0]         seed = 32'h3BEFABE8;
  logic [31:0]         wa, wb;
  logic [31:0]         fq[$];
  logic [23:0]         rq[$];
  int                  n_errors = 0;
  int                  comparisons = 0;

  // Clock, 40 ns period
  always #20 clock_i = ~clock_i;

  event_status_latch uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
    .levels_i(levels_i), .switch_inputs_i(sw), .poll_trigger_i(poll_trigger_i),
    .poll_done_i(poll_done_i), .frame_done_i(frame_done), .frame_bits_i(frame_bits),
    .stat_read_i(stat_read), .cs_rise_i(cs_rise), .event_flags_o(flags), .read_word_o(read_word),
    .parity_frame_flag_o(pflag), .frame_accept_o(accept), .frame_word_o(frame_word), .int_n_o(int_n));

  host_model h (.clock_i(clock_i), .frame_done_o(frame_done), .frame_bits_o(frame_bits),
    .stat_read_o(stat_read), .cs_rise_o(cs_rise));
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask : tick

  // Note the snapshot, then a full read frame
  task automatic rd(input logic [23:0] exp);
    rq.push_back(exp);
    h.read_cmd();
    h.cs_end();
  endtask : rd

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  // Watcher: results sampled one edge after they launch, so no race
  always @(posedge clock_i) begin
    if (rd_d) check("read_word", read_word, rq.pop_front());
    if (accept === 1'h1) check("frame_word", frame_word, fq.size() ? fq.pop_front() : 'x);
    rd_d <= stat_read;
  end
  ////////////////////////////////////////
  initial begin
    tick(10);
    sys_rst_i = 1'h0;
    tick(1);
    check("flags", flags, FLAGS_RST);
    check("int_n", int_n, 1'h0);
    rq.push_back(FLAGS_RST);
    h.read_cmd();
    check("int_n", int_n, 1'h0);
    h.cs_end();
    check("int_n", int_n, 1'h1);
    // Each monitor: set on start, held, set again on end
    for (int i = 0; i < 4; i++) begin
      levels_i[i] = 1'h1;
      tick(3);
      check("flags", flags, 24'h1 << (i + 4));
      check("int_n", int_n, 1'h0);
      rd(24'h1 << (i + 4));
      levels_i[i] = 1'h0;
      rd(24'h1 << (i + 4));
    end
    // Random switch crossings
    for (int i = 0; i < 3; i++) begin
      seed = nxt(seed);
      sw = sw ^ (seed[23:0] | 24'h1);
      tick(2);
      rd(24'h8);
      check("flags", flags, 24'h0);
    end
    // Only the first completed poll after a trigger
    poll_trigger_i = 1'h1;
    tick(1);
    poll_trigger_i = 1'h0;
    rd(24'h0);
    for (int i = 0; i < 2; i++) begin
      poll_done_i = 1'h1;
      tick(1);
      poll_done_i = 1'h0;
      rd(i ? 24'h0 : 24'h8);
    end
    // Trigger with the first poll completing on the very next cycle
    poll_trigger_i = 1'h1;
    tick(1);
    poll_trigger_i = 1'h0;
    poll_done_i    = 1'h1;
    tick(1);
    poll_done_i    = 1'h0;
    rd(24'h8);
    // Good then bad frame back to back, then two good ones
    seed = nxt(seed);
    wa = h.seal(seed, 1'h0);
    wb = h.seal(~seed, 1'h1);
    fq.push_back(wa);
    h.frames(wa, wb);
    tick(1);
    check("pflag", pflag, 1'h1);
    check("flags", flags, 24'h4);
    seed = nxt(seed);
    wa = h.seal(seed, 1'h0);
    wb = h.seal(~seed, 1'h0);
    fq.push_back(wa);
    fq.push_back(wb);
    h.frames(wa, wb);
    tick(1);
    rd(24'h4);
    check("pflag", pflag, 1'h0);
    // Soft reset, then hard reset in mid-run
    soft_rst_i = 1'h1;
    tick(1);
    soft_rst_i = 1'h0;
    tick(1);
    check("flags", flags, FLAGS_RST);
    sys_rst_i = 1'h1;
    tick(1);
    check("flags", flags, FLAGS_RST);
    check("int_n", int_n, 1'h0);
    sys_rst_i = 1'h0;
    tick(2);
    check("flags", flags, 24'h9);
    check("pending", fq.size() + rq.size(), 32'h0);
    finish_test();
  end
endmodule : event_status_latch_tb
